//--- dv/rca_calendar_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module rca_calendar_chk (
  input wire       clk,           // clock
  input wire       rst_n,         // reset, active low
  input wire       chipEnable,    // access in progress
  input wire       secondTick,    // 1 Hz tick pin
  input wire       timeStep,      // seconds advance
  input wire [7:0] monthValue,    // month copy
  input wire [7:0] yearValue,     // year copy
  input wire       alarmIntOut,   // open-drain data
  input wire       s_axi_arvalid, // read address valid
  input wire       s_axi_arready, // read address ready
  input wire       s_axi_rvalid,  // read data valid
  input wire       s_axi_bvalid,  // write response valid
  input wire       s_axi_bready   // write response ready
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg pend;
  // tick seen inside a frame, owed once the frame ends
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pend <= 1'b0;
    else if (timeStep)
      pend <= 1'b0;
    else if (chipEnable && $rose(secondTick))
      pend <= 1'b1;
  end
  // six cycles lets the pin synchroniser catch up
  sequence busyRun;
    chipEnable [*6];
  endsequence
  sequence frameEnd;
    $fell(chipEnable) ##0 pend;
  endsequence
  AST_HOLD: assert property (busyRun |-> !timeStep)
    else $error("seconds advanced during access");
  AST_RELEASE: assert property (frameEnd |-> ##[1:8] timeStep)
    else $error("pending tick not applied");
  AST_STEP_ONE: assert property (timeStep |=> !timeStep)
    else $error("more than one advance");
  AST_MONTH_ZERO: assert property (monthValue[7:5] == 3'b000)
    else $error("month upper bits set");
  AST_MONTH_BCD: assert property (
    monthValue[4:0] inside {[1:9], [16:18]})
    else $error("month out of range");
  AST_YEAR_BCD: assert property (
    yearValue[7:4] < 4'ha && yearValue[3:0] < 4'ha)
    else $error("year not bcd");
  AST_PIN_LOW: assert property (alarmIntOut == 1'b0)
    else $error("interrupt pin driven high");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule // rca_calendar_chk

bind rca_calendar rca_calendar_chk rca_calendar_chk_inst (
  .clk(clk), .rst_n(rst_n), .chipEnable(chipEnable),
  .secondTick(secondTick), .timeStep(timeStep), .monthValue(monthValue),
  .yearValue(yearValue), .alarmIntOut(alarmIntOut),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));

//--- dv/rca_host_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// serial host: chip enable spans one whole access
// ------------------------------------------------------------
module rca_host_model (
  input  wire        clk,        // clock
  input  wire        start,      // begin an access
  input  wire [15:0] frameLen,   // access length, cycles
  output reg         chipEnable  // high during access
);
  reg [15:0] left;
  initial chipEnable = 1'b0;
  initial left = 16'h0000;
  // one unbroken access, far below a second
  always @(posedge clk) begin
    if (start) begin
      chipEnable <= 1'b1;
      left <= frameLen;
    end else if (left != 16'h0000)
      left <= left - 16'h0001;
    else
      chipEnable <= 1'b0;
  end
endmodule // rca_host_model

//--- dv/test_rca_calendar.sv
`timescale 1ns/10ps
`include "rca_regs.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t mismatch line %0d", $time, `__LINE__); \
  end end

module test_rca_calendar;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h1; // registers sit in lane 0 only
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic        s_axi_rready = 1'b1, secondTick = 1'b0;
  logic        monthCarry = 1'b0, frameStart = 1'b0;
  logic [7:0]  curMinute = 8'h29, curHour = 8'h01;
  logic [7:0]  curDay = 8'h31, curWeekday = 8'h05;
  logic [15:0] frameLen = 16'h0000;
  logic [31:0] rdat;
  logic [1:0]  rsp;
  int          fail_count = 0, total_checks = 0, steps = 0;
  wire         chipEnable, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid, timeStep, hourFormat12;
  wire         alarmIntOut, alarmIntOe, irq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   monthValue, yearValue;

  rca_calendar rca_calendar_inst (.clk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .chipEnable, .secondTick, .curMinute, .curHour, .curDay,
    .curWeekday, .monthCarry, .timeStep, .hourFormat12, .monthValue,
    .yearValue, .alarmIntOut, .alarmIntOe, .irq);
  rca_host_model rca_host_model_inst (.clk(clk), .start(frameStart),
    .frameLen(frameLen), .chipEnable(chipEnable));

  // clock and seconds-advance tally
  always #20 clk = ~clk;
  always @(posedge clk) if (timeStep === 1'b1) steps <= steps + 1;

  task close_out;
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // bus and pin helpers
  // ------------------------------------------------------------
  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input [7:0] idx, input [7:0] d);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input [7:0] idx);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // tick high for half of a 320 ns period
  task tick;
    secondTick <= 1'b1;
    waitc(4);
    secondTick <= 1'b0;
    waitc(4);
  endtask
  task carry;
    monthCarry <= 1'b1;
    waitc(1);
    monthCarry <= 1'b0;
    waitc(2);
  endtask
  task frame(input [15:0] len);
    frameLen <= len;
    frameStart <= 1'b1;
    waitc(1);
    frameStart <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    rd(`RCA_IDX_MONTH);
    `CHK(rdat, 32'h01)
    rd(`RCA_IDX_YEAR);
    `CHK(rdat, 32'h00)
    for (int i = 9; i < 13; i++) begin
      rd(i[7:0]);
      `CHK(rdat, 32'h80)
    end
    rd(8'h3f);
    `CHK(rsp, `RCA_RESP_SLVERR)
    wr(8'h3f, 8'h00);
    `CHK(rsp, `RCA_RESP_SLVERR)
    wr(`RCA_IDX_MONTH, 8'hf2);
    `CHK(rsp, `RCA_RESP_OKAY)
    rd(`RCA_IDX_MONTH);
    `CHK(rdat, 32'h12)
    // a write with lane 0 masked must leave the year alone
    s_axi_wstrb <= 4'h0;
    wr(`RCA_IDX_YEAR, 8'h55);
    s_axi_wstrb <= 4'h1;
    `CHK(rsp, `RCA_RESP_OKAY)
    rd(`RCA_IDX_YEAR);
    `CHK(rdat, 32'h00)
  endtask
  // december wraps into january and the next year
  task t_cal;
    wr(`RCA_IDX_YEAR, 8'h09);
    carry;
    `CHK(monthValue, 8'h01)
    `CHK(yearValue, 8'h10)
    wr(`RCA_IDX_MONTH, 8'h09);
    carry;
    `CHK(monthValue, 8'h10)
  endtask
  task t_hold;
    int s;
    s = steps;
    tick;
    `CHK(steps, s + 1)
    frame(16'd80);
    waitc(6);
    tick;
    carry;
    `CHK(monthValue, 8'h10)
    `CHK(steps, s + 1)
    waitc(80);
    `CHK(steps, s + 2)
    frame(16'd100);
    waitc(6);
    tick;
    tick;
    waitc(100);
    `CHK(steps, s + 3)
    rd(`RCA_IDX_IRQ_STAT);
    `CHK(rdat[1], 1'b1)
    wr(`RCA_IDX_IRQ_CLR, 8'h02);
    rd(`RCA_IDX_IRQ_STAT);
    `CHK(rdat[1], 1'b0)
  endtask
  task t_alarm;
    wr(`RCA_IDX_CTRL2, 8'h02);
    wr(`RCA_IDX_IRQ_EN, 8'h01);
    wr(`RCA_IDX_MIN_MATCH, 8'h30);
    wr(`RCA_IDX_WD_MATCH, 8'h05);
    `CHK(alarmIntOe, 1'b0)
    curMinute <= 8'h30;
    waitc(3);
    `CHK(alarmIntOe, 1'b1)
    `CHK(alarmIntOut, 1'b0)
    `CHK(irq, 1'b1)
    wr(`RCA_IDX_CTRL2, 8'h0a);
    `CHK(alarmIntOe, 1'b1)
    wr(`RCA_IDX_IRQ_EN, 8'h00);
    `CHK(irq, 1'b0)
    wr(`RCA_IDX_IRQ_EN, 8'h01);
    wr(`RCA_IDX_CTRL2, 8'h02);
    rd(`RCA_IDX_CTRL2);
    `CHK(rdat[3], 1'b0)
    `CHK(alarmIntOe, 1'b0)
    wr(`RCA_IDX_IRQ_CLR, 8'h01);
    waitc(4);
    `CHK(irq, 1'b0)
    `CHK(alarmIntOe, 1'b0)
    // weekday now differs, so a minute match alone must not fire
    curWeekday <= 8'h04;
    curMinute <= 8'h31;
    waitc(2);
    curMinute <= 8'h30;
    waitc(3);
    `CHK(alarmIntOe, 1'b0)
    curWeekday <= 8'h05;
    waitc(3);
    `CHK(alarmIntOe, 1'b1)
    wr(`RCA_IDX_CTRL1, 8'h04);
    `CHK(hourFormat12, 1'b1)
    wr(`RCA_IDX_HR_MATCH, 8'h21);
    wr(`RCA_IDX_MIN_MATCH, 8'h80);
    wr(`RCA_IDX_WD_MATCH, 8'h80);
    wr(`RCA_IDX_DAY_MATCH, 8'h31);
    wr(`RCA_IDX_CTRL2, 8'h02);
    waitc(3);
    `CHK(alarmIntOe, 1'b0)
    curHour <= 8'h21;
    waitc(3);
    `CHK(alarmIntOe, 1'b1)
  endtask

  // main sequence: reset, then every scenario in turn
  initial begin
    waitc(8);
    rst_n <= 1'b1;
    waitc(1);
    t_regs;
    t_cal;
    t_hold;
    t_alarm;
    close_out;
  end
  // watchdog well past the expected run length
  initial begin
    #400000;
    fail_count++;
    close_out;
  end
endmodule // test_rca_calendar

//--- verilog/rca_calendar.v
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "rca_regs.vh"

// Operation
// - month register, bits 7..5 read zero
// - months counted BCD one through twelve
// - year register holds two BCD digits
// - hold time counting during serial access
// - apply one pending tick after access
// - compare only alarms with enable zero
// - minute alarm: disable bit, BCD minute
// - hour alarm: disable bit, hour fields
// - hour alarm layout follows hour format
// - day alarm: disable bit, BCD day
// - weekday alarm: disable bit, value 0-6
// - flag sets on first match only
// - flag writes AND with current value
// - interrupt pin follows flag when enabled
module rca_calendar (
  input  wire        clk,           // 25 MHz system clock
  input  wire        rst_n,         // async reset, active low
  input  wire [7:0]  s_axi_awaddr,  // write address
  input  wire        s_axi_awvalid, // write address valid
  output wire        s_axi_awready, // write address ready
  input  wire [31:0] s_axi_wdata,   // write data
  input  wire [3:0]  s_axi_wstrb,   // write byte strobes
  input  wire        s_axi_wvalid,  // write data valid
  output wire        s_axi_wready,  // write data ready
  output reg  [1:0]  s_axi_bresp,   // write response
  output reg         s_axi_bvalid,  // write response valid
  input  wire        s_axi_bready,  // write response ready
  input  wire [7:0]  s_axi_araddr,  // read address
  input  wire        s_axi_arvalid, // read address valid
  output wire        s_axi_arready, // read address ready
  output reg  [31:0] s_axi_rdata,   // read data
  output reg  [1:0]  s_axi_rresp,   // read response
  output reg         s_axi_rvalid,  // read data valid
  input  wire        s_axi_rready,  // read data ready
  input  wire        chipEnable,    // serial chip enable pin
  input  wire        secondTick,    // 1 Hz tick pin
  input  wire [7:0]  curMinute,     // current minute, BCD
  input  wire [7:0]  curHour,       // current hour, BCD
  input  wire [7:0]  curDay,        // current day, BCD
  input  wire [7:0]  curWeekday,    // current weekday
  input  wire        monthCarry,    // day counter wrapped, pulse
  output reg         timeStep,      // advance seconds counter
  output wire        hourFormat12,  // hour format to counters
  output reg  [7:0]  monthValue,    // month register copy
  output reg  [7:0]  yearValue,     // year register copy
  output wire        alarmIntOut,   // open-drain int level
  output wire        alarmIntOe,    // int pin driven low
  output wire        irq            // level interrupt
);

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  reg  [1:0] ceSync;
  reg  [1:0] tickSync;
  reg        ceLast;
  reg        tickLast;
  wire       accessBusy = ceSync[1];
  wire       tickRise   = tickSync[1] & ~tickLast;
  wire       accessEnd  = ceLast & ~ceSync[1];

  // two stages before any logic looks at the pins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ceSync   <= 2'b00;
      tickSync <= 2'b00;
      ceLast   <= 1'b0;
      tickLast <= 1'b0;
    end else begin
      ceSync   <= {ceSync[0], chipEnable};
      tickSync <= {tickSync[0], secondTick};
      ceLast   <= ceSync[1];
      tickLast <= tickSync[1];
    end
  end

  // ---------------------------------------------------------------
  // counter hold and pending increment
  // ---------------------------------------------------------------
  reg pendingStep;
  reg tickLost;

  // one pending slot only; a second tick while held is dropped
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendingStep <= 1'b0;
      timeStep    <= 1'b0;
      tickLost    <= 1'b0;
    end else begin
      timeStep <= 1'b0;
      tickLost <= 1'b0;
      if (accessBusy) begin
        if (tickRise) begin
          pendingStep <= 1'b1;
          tickLost    <= pendingStep;
        end
      end else if (accessEnd && (pendingStep || tickRise)) begin
        timeStep    <= 1'b1;
        pendingStep <= 1'b0;
      end else if (tickRise) begin
        timeStep <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // alarm comparison
  // ---------------------------------------------------------------
  reg  [7:0] minMatch;
  reg  [7:0] hrMatch;
  reg  [7:0] dayMatch;
  reg  [7:0] wdMatch;
  reg  [7:0] ctrl1;
  wire [5:0] hourMask;
  wire       minHit;
  wire       hrHit;
  wire       dayHit;
  wire       wdHit;
  wire       anyEnabled;
  wire       alarmMatch;

  assign hourFormat12 = ctrl1[`RCA_CTRL1_HOUR12];
  // both layouts occupy bits 5..0: pm flag plus one tens bit, or
  // two tens bits, so only the meaning differs, not the mask
  assign hourMask = hourFormat12 ? 6'h3f : 6'h3f;

  // a disabled comparison counts as a hit
  assign minHit = minMatch[`RCA_MATCH_DIS] |
                  (minMatch[6:0] == curMinute[6:0]);
  assign hrHit  = hrMatch[`RCA_MATCH_DIS] |
                  ((hrMatch[5:0] & hourMask) ==
                   (curHour[5:0] & hourMask));
  assign dayHit = dayMatch[`RCA_MATCH_DIS] |
                  (dayMatch[5:0] == curDay[5:0]);
  assign wdHit  = wdMatch[`RCA_MATCH_DIS] |
                  (wdMatch[2:0] == curWeekday[2:0]);
  // with every comparison disabled the alarm never fires
  assign anyEnabled = ~(minMatch[7] & hrMatch[7] &
                        dayMatch[7] & wdMatch[7]);
  assign alarmMatch = anyEnabled & minHit & hrHit & dayHit & wdHit;

  // ---------------------------------------------------------------
  // alarm flag and interrupt status
  // ---------------------------------------------------------------
  reg        alarmFlag;
  reg        alarmIrqEnable;
  reg        matchLast;
  reg  [1:0] irqStat;
  reg  [1:0] irqEn;
  wire       alarmSet = alarmMatch & ~matchLast;
  wire       ctrl2Wr;
  wire       clrWr;
  wire [7:0] wrByte;

  // flag rises only on entry into a match, so a cleared flag stays
  // clear for the rest of that matching period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      matchLast <= 1'b0;
      alarmFlag <= 1'b0;
      irqStat   <= 2'b00;
    end else begin
      matchLast <= alarmMatch;
      // set wins over a clearing write in the same cycle
      if (alarmSet)
        alarmFlag <= 1'b1;
      else if (ctrl2Wr)
        alarmFlag <= alarmFlag & wrByte[`RCA_CTRL2_AFLAG];
      irqStat[`RCA_IRQ_ALARM] <= alarmSet |
        (irqStat[`RCA_IRQ_ALARM] &
         ~(clrWr & wrByte[`RCA_IRQ_ALARM]));
      irqStat[`RCA_IRQ_LOST] <= tickLost |
        (irqStat[`RCA_IRQ_LOST] &
         ~(clrWr & wrByte[`RCA_IRQ_LOST]));
    end
  end

  // pin pulled low while flag and enable are both set
  assign alarmIntOut = 1'b0;
  assign alarmIntOe  = alarmFlag & alarmIrqEnable;
  assign irq         = |(irqStat & irqEn);

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  reg        awHeld;
  reg        wHeld;
  reg  [7:0] awIdx;
  reg  [7:0] wByte;
  reg        wLaneOk;
  wire       doWrite = awHeld & wHeld & ~s_axi_bvalid;
  wire       wrMapped;

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
  assign wrByte  = wByte;
  assign ctrl2Wr = doWrite & wLaneOk & (awIdx == `RCA_IDX_CTRL2);
  assign clrWr   = doWrite & wLaneOk & (awIdx == `RCA_IDX_IRQ_CLR);
  assign wrMapped = (awIdx == `RCA_IDX_CTRL1) |
                    (awIdx == `RCA_IDX_CTRL2) |
                    ((awIdx >= `RCA_IDX_MONTH) &
                     (awIdx <= `RCA_IDX_WD_MATCH)) |
                    (awIdx == `RCA_IDX_IRQ_STAT) |
                    (awIdx == `RCA_IDX_IRQ_CLR) |
                    (awIdx == `RCA_IDX_IRQ_EN);

  // address and data are caught in either order, answer after both
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awIdx        <= 8'h00;
      wByte        <= 8'h00;
      wLaneOk      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RCA_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awIdx  <= {2'b00, s_axi_awaddr[7:2]};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld   <= 1'b1;
        wByte   <= s_axi_wdata[7:0];
        wLaneOk <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register file and calendar counting
  // ---------------------------------------------------------------
  reg  [7:0] next_month;
  reg        yearCarry;
  reg  [7:0] next_year;
  wire       regWr = doWrite & wLaneOk;

  // bcd month 01..12 wraps to 01 and carries into the year
  always @* begin
    yearCarry = 1'b0;
    if (monthValue[4:0] == 5'h12) begin
      next_month = 8'h01;
      yearCarry  = 1'b1;
    end else if (monthValue[3:0] == 4'h9) begin
      next_month = 8'h10;
    end else begin
      next_month = {3'b000, monthValue[4:0] + 5'h01};
    end
    if (yearValue == 8'h99)
      next_year = 8'h00;
    else if (yearValue[3:0] == 4'h9)
      next_year = {yearValue[7:4] + 4'h1, 4'h0};
    else
      next_year = {yearValue[7:4], yearValue[3:0] + 4'h1};
  end

  // carry arrives on monthCarry and is ignored while accessBusy is high, not held
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monthValue     <= `RCA_RST_MONTH;
      yearValue      <= `RCA_RST_YEAR;
      minMatch       <= `RCA_RST_MATCH;
      hrMatch        <= `RCA_RST_MATCH;
      dayMatch       <= `RCA_RST_MATCH;
      wdMatch        <= `RCA_RST_MATCH;
      ctrl1          <= `RCA_RST_CTRL1;
      alarmIrqEnable <= 1'b0;
      irqEn          <= 2'b00;
    end else begin
      if (monthCarry && !accessBusy) begin
        monthValue <= next_month;
        if (yearCarry)
          yearValue <= next_year;
      end
      if (regWr) begin
        case (awIdx)
          `RCA_IDX_CTRL1:
            ctrl1 <= {5'h00, wByte[`RCA_CTRL1_HOUR12], 2'b00};
          `RCA_IDX_CTRL2:
            alarmIrqEnable <= wByte[`RCA_CTRL2_AIE];
          `RCA_IDX_MONTH:     monthValue <= {3'b000, wByte[4:0]};
          `RCA_IDX_YEAR:      yearValue  <= wByte;
          `RCA_IDX_MIN_MATCH: minMatch   <= wByte;
          `RCA_IDX_HR_MATCH:  hrMatch    <= {wByte[7], 1'b0, wByte[5:0]};
          `RCA_IDX_DAY_MATCH: dayMatch   <= {wByte[7], 1'b0, wByte[5:0]};
          `RCA_IDX_WD_MATCH:  wdMatch    <= {wByte[7], 4'h0, wByte[2:0]};
          `RCA_IDX_IRQ_EN:    irqEn      <= wByte[1:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  reg  [7:0] rdByte;
  reg        rdMapped;
  wire [7:0] arIdx = {2'b00, s_axi_araddr[7:2]};

  assign s_axi_arready = ~s_axi_rvalid;

  // read mux; unused bits and reserved positions return zero
  always @* begin
    rdMapped = 1'b1;
    case (arIdx)
      `RCA_IDX_CTRL1:     rdByte = ctrl1;
      `RCA_IDX_CTRL2:     rdByte = {4'h0, alarmFlag, 1'b0,
                                    alarmIrqEnable, 1'b0};
      `RCA_IDX_MONTH:     rdByte = {3'b000, monthValue[4:0]};
      `RCA_IDX_YEAR:      rdByte = yearValue;
      `RCA_IDX_MIN_MATCH: rdByte = minMatch;
      `RCA_IDX_HR_MATCH:  rdByte = hrMatch;
      `RCA_IDX_DAY_MATCH: rdByte = dayMatch;
      `RCA_IDX_WD_MATCH:  rdByte = wdMatch;
      `RCA_IDX_IRQ_STAT:  rdByte = {6'h00, irqStat};
      `RCA_IDX_IRQ_CLR:   rdByte = 8'h00;
      `RCA_IDX_IRQ_EN:    rdByte = {6'h00, irqEn};
      default: begin
        rdByte   = 8'h00;
        rdMapped = 1'b0;
      end
    endcase
  end

  // one read outstanding; data captured when address is taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RCA_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= rdMapped ? `RCA_RESP_OKAY : `RCA_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rca_calendar

//--- verilog/rca_regs.vh
`ifndef RCA_REGS_VH
`define RCA_REGS_VH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define RCA_IDX_CTRL1     8'h00
`define RCA_IDX_CTRL2     8'h01
`define RCA_IDX_MONTH     8'h07
`define RCA_IDX_YEAR      8'h08
`define RCA_IDX_MIN_MATCH 8'h09
`define RCA_IDX_HR_MATCH  8'h0a
`define RCA_IDX_DAY_MATCH 8'h0b
`define RCA_IDX_WD_MATCH  8'h0c
`define RCA_IDX_IRQ_STAT  8'h10
`define RCA_IDX_IRQ_CLR   8'h11
`define RCA_IDX_IRQ_EN    8'h12

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RCA_CTRL1_HOUR12  2
`define RCA_CTRL2_AFLAG   3
`define RCA_CTRL2_AIE     1
`define RCA_MATCH_DIS     7
`define RCA_IRQ_ALARM     0
`define RCA_IRQ_LOST      1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RCA_RST_MONTH     8'h01
`define RCA_RST_YEAR      8'h00
`define RCA_RST_MATCH     8'h80
`define RCA_RST_CTRL1     8'h00

// ---------------------------------------------------------------
// bus answers
// ---------------------------------------------------------------
`define RCA_RESP_OKAY     2'b00
`define RCA_RESP_SLVERR   2'b10

`endif
